// ===== rtl/ssbp_ms_timer.v
// Millisecond tick generator and saturating millisecond counter
`default_nettype none
`include "ssbp_consts.vh"

module ssbp_ms_timer #(
    parameter CYC_PER_MS = `SSBP_CYC_PER_MS,
    parameter CW         = 17
) (
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    input  wire        run_i,
    output wire [15:0] ms_o
);

    reg [CW-1:0] pre_q;
    reg [15:0]   ms_q;

    // Prescaler restarts whenever counting stops, so each run starts at 0 ms
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_q <= {CW{1'b0}};
            ms_q  <= 16'h0000;
        end else if (!run_i) begin
            pre_q <= {CW{1'b0}};
            ms_q  <= 16'h0000;
        end else if (pre_q == CYC_PER_MS[CW-1:0] - 1'b1) begin
            pre_q <= {CW{1'b0}};
            if (ms_q != 16'hffff) begin
                ms_q <= ms_q + 16'h0001;  // Saturates, never wraps
            end
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    assign ms_o = ms_q;

endmodule // ssbp_ms_timer

`default_nettype wire

// ===== rtl/ssbp_top.v
// Servo stop behaviour, dynamic brake timing and stall protection
// Behaviour
// - Masked warnings do not flash on the seven-segment displays.
// - Hold torque limits two to four, 0..3000 in 0.1 percent, default 3000.
// - Position modes: rated current longer than stall time raises alarm, disables motor.
// - Servo off applies action 0..5: ramp, coast or brake, then coast or hold.
// - Error applies action 0..3: coast or brake, then coast or hold.
// - Error stop limits braking by the error-case maximum brake time.
// - Deceleration ends at zero-speed threshold or max brake time, whichever first.
// - Disable-case maximum brake time 0..30000 ms, default 500 ms.
// - Past disable-case max time the brake releases even above zero speed.
// - Ramp stops use the maximum acceleration/deceleration rate.
`default_nettype none
`include "ssbp_consts.vh"

module ssbp_top #(
    parameter SPW = 16,
    parameter AW  = 16
) (
    input  wire           sys_clk_i,
    input  wire           rstn_i,
    // Parameter loads, one strobe each, except limits three and four, which share one strobe
    input  wire           torque_limit_two_cmd_i,
    input  wire           torque_limit_three_four_cmd_i,
    input  wire           torque_sel_four_i,
    input  wire [11:0]    torque_limit_val_i,
    input  wire           stall_protect_cmd_i,
    input  wire           disable_stop_action_cmd_i,
    input  wire           error_stop_action_cmd_i,
    input  wire           disable_brake_max_time_cmd_i,
    input  wire           error_brake_max_time_cmd_i,
    input  wire [15:0]    time_val_i,
    input  wire [2:0]     action_val_i,
    input  wire [31:0]    warning_display_mask_i,
    input  wire [31:0]    warning_active_i,
    // Drive state
    input  wire           servo_on_i,
    input  wire           error_i,
    input  wire           pos_mode_i,
    input  wire           at_rated_current_i,
    input  wire [SPW-1:0] motor_speed_i,
    input  wire [SPW-1:0] zero_speed_threshold_i,
    input  wire [AW-1:0]  max_accel_decel_i,
    // Outputs
    output reg  [31:0]    warning_flash_o,
    output reg  [11:0]    torque_limit_two_o,
    output reg  [11:0]    torque_limit_three_o,
    output reg  [11:0]    torque_limit_four_o,
    output reg            stall_alarm_o,
    output reg  [1:0]     stage_mode_o,
    output reg  [AW-1:0]  decel_rate_o,
    output reg            decel_active_o,
    output reg  [15:0]    brake_elapsed_ms_o
);

    localparam ST_RUN  = 2'd0;
    localparam ST_DEC  = 2'd1;
    localparam ST_DONE = 2'd2;

    // ************************************************************
    // Settings
    // ************************************************************
    reg [14:0] stall_time_q;
    reg [14:0] dis_brake_q;
    reg [14:0] err_brake_q;
    reg [2:0]  dis_act_q;
    reg [1:0]  err_act_q;
    reg [1:0]  state_q;
    reg [1:0]  state_d;
    reg        err_stop_q;
    reg        stall_run_q;
    reg        stopping_d;
    reg [1:0]  mode_d;

    wire [15:0] stall_ms;
    wire [15:0] brake_ms;

    // Magnitude of a two's-complement speed, used more than once
    function [SPW-1:0] mag;
        input [SPW-1:0] v;
        begin
            mag = v[SPW-1] ? (~v + 1'b1) : v;
        end
    endfunction

    // Out-of-range writes are ignored so the old setting stays valid
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            torque_limit_two_o   <= `SSBP_TORQUE_RST;
            torque_limit_three_o <= `SSBP_TORQUE_RST;
            torque_limit_four_o  <= `SSBP_TORQUE_RST;
            stall_time_q         <= `SSBP_STALL_TIME_RST;
            dis_brake_q          <= `SSBP_DIS_BRAKE_RST;
            err_brake_q          <= `SSBP_ERR_BRAKE_RST;
            dis_act_q            <= 3'd0;
            err_act_q            <= 2'd0;
        end else begin
            if (torque_limit_two_cmd_i && torque_limit_val_i <= `SSBP_TORQUE_MAX) begin
                torque_limit_two_o <= torque_limit_val_i;
            end
            if (torque_limit_three_four_cmd_i && torque_limit_val_i <= `SSBP_TORQUE_MAX) begin
                if (torque_sel_four_i) begin
                    torque_limit_four_o <= torque_limit_val_i;
                end else begin
                    torque_limit_three_o <= torque_limit_val_i;
                end
            end
            if (stall_protect_cmd_i && time_val_i[14:0] <= `SSBP_TIME_MAX && !time_val_i[15]) begin
                stall_time_q <= time_val_i[14:0];
            end
            if (disable_brake_max_time_cmd_i && time_val_i <= {1'b0, `SSBP_TIME_MAX}) begin
                dis_brake_q <= time_val_i[14:0];
            end
            if (error_brake_max_time_cmd_i && time_val_i <= {1'b0, `SSBP_TIME_MAX}) begin
                err_brake_q <= time_val_i[14:0];
            end
            if (disable_stop_action_cmd_i && action_val_i <= `SSBP_DIS_ACT_MAX) begin
                dis_act_q <= action_val_i;
            end
            if (error_stop_action_cmd_i && action_val_i <= {1'b0, `SSBP_ERR_ACT_MAX}) begin
                err_act_q <= action_val_i[1:0];
            end
        end
    end

    // ************************************************************
    // Warning display
    // ************************************************************
    // Mask display flash
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            warning_flash_o <= 32'h00000000;
        end else begin
            warning_flash_o <= warning_active_i & ~warning_display_mask_i;
        end
    end

    // ************************************************************
    // Stall protection
    // ************************************************************
    // Timer runs only while stalled in a position mode and servo is on
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stall_run_q <= 1'b0;
        end else begin
            stall_run_q <= servo_on_i && pos_mode_i && at_rated_current_i && !stall_alarm_o;
        end
    end

    ssbp_ms_timer u_stall_timer (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (stall_run_q),
        .ms_o      (stall_ms)
    );

    // Alarm is sticky until servo is off with no error present; while set it acts as an error stop
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stall_alarm_o <= 1'b0;
        end else if (stall_run_q && stall_ms > {1'b0, stall_time_q}) begin
            stall_alarm_o <= 1'b1;
        end else if (!servo_on_i && !error_i) begin
            stall_alarm_o <= 1'b0;
        end
    end

    // ************************************************************
    // Stop sequencer
    // ************************************************************
    wire run_req = servo_on_i && !error_i && !stall_alarm_o;
    wire err_now = error_i || stall_alarm_o;
    wire at_zero = mag(motor_speed_i) <= mag(zero_speed_threshold_i);
    wire [14:0] lim = err_stop_q ? err_brake_q : dis_brake_q;
    wire dec_end = at_zero || brake_ms >= {1'b0, lim};

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (!run_req) begin
                    state_d = ST_DEC;
                end
            end
            ST_DEC: begin
                if (run_req) begin
                    state_d = ST_RUN;
                end else if (dec_end) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (run_req) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN;
        endcase
    end

    // Stage mode from the stored action codes; error takes priority over off
    always @* begin
        stopping_d = (state_d == ST_DEC);
        mode_d     = `SSBP_STAGE_RUN;
        if (state_d == ST_DEC) begin
            if (err_stop_q || (state_q == ST_RUN && err_now)) begin
                mode_d = err_act_q[1] ? `SSBP_STAGE_BRAKE : `SSBP_STAGE_COAST;
            end else begin
                if (dis_act_q <= 3'd1) begin
                    mode_d = `SSBP_STAGE_RAMP;
                end else if (dis_act_q <= 3'd3) begin
                    mode_d = `SSBP_STAGE_COAST;
                end else begin
                    mode_d = `SSBP_STAGE_BRAKE;
                end
            end
        end else if (state_d == ST_DONE) begin
            // Odd codes hold the brake only once the shaft is at rest
            // a stop cut short by the time limit leaves the motor free
            if (err_stop_q) begin
                mode_d = (err_act_q[0] && at_zero) ? `SSBP_STAGE_BRAKE : `SSBP_STAGE_COAST;
            end else begin
                mode_d = (dis_act_q[0] && at_zero) ? `SSBP_STAGE_BRAKE : `SSBP_STAGE_COAST;
            end
        end
    end

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q        <= ST_RUN;
            err_stop_q     <= 1'b0;
            stage_mode_o   <= `SSBP_STAGE_RUN;
            decel_active_o <= 1'b0;
            decel_rate_o   <= {AW{1'b0}};
        end else begin
            state_q <= state_d;
            if (state_q == ST_RUN && state_d == ST_DEC) begin
                err_stop_q <= err_now;  // Latched at stop start
            end else if (state_d == ST_RUN) begin
                err_stop_q <= 1'b0;
            end
            stage_mode_o   <= mode_d;
            decel_active_o <= stopping_d;
            decel_rate_o   <= max_accel_decel_i;
        end
    end

    ssbp_ms_timer u_brake_timer (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .run_i     (state_q == ST_DEC),
        .ms_o      (brake_ms)
    );

    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brake_elapsed_ms_o <= 16'h0000;
        end else begin
            brake_elapsed_ms_o <= brake_ms;
        end
    end

endmodule // ssbp_top

`default_nettype wire

// ===== shared/ssbp_consts.vh
// Constants for the servo stop, brake and stall protection block
`ifndef SSBP_CONSTS_VH
`define SSBP_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define SSBP_CLK_MHZ          100
`define SSBP_MS_NS            1000000
`define SSBP_CLK_NS           10
`define SSBP_CYC_PER_MS       (`SSBP_MS_NS / `SSBP_CLK_NS)

// ****************************************************************
// Setting ranges and reset values
// ****************************************************************
`define SSBP_TORQUE_MAX       12'd3000
`define SSBP_TORQUE_RST       12'd3000
`define SSBP_TIME_MAX         15'd30000
`define SSBP_STALL_TIME_RST   15'd0
`define SSBP_DIS_BRAKE_RST    15'd500
`define SSBP_ERR_BRAKE_RST    15'd0
`define SSBP_DIS_ACT_MAX      3'd5
`define SSBP_ERR_ACT_MAX      2'd3
`define SSBP_MASK_RST         32'hffffffff

// ****************************************************************
// Output stage modes
// ****************************************************************
`define SSBP_STAGE_RUN        2'd0
`define SSBP_STAGE_RAMP       2'd1
`define SSBP_STAGE_COAST      2'd2
`define SSBP_STAGE_BRAKE      2'd3

`endif

// ===== tb/servo_stop_brake_protection_bench.sv
// Self-checking bench for the stop, brake and stall block
`default_nettype none
module servo_stop_brake_protection_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rstn = 1'b0, sel4 = 1'b0, son = 1'b0, err = 1'b0;
    logic        pos = 1'b0, stall = 1'b0, load = 1'b0;
    logic [6:0]  cmd = 7'h0;
    logic [11:0] tval = 12'h0;
    logic [15:0] time_v = 16'h0;
    logic [2:0]  act = 3'h0;
    logic [31:0] mask = 32'h0, wact = 32'h0, seed = 32'h7798;
    logic [15:0] thr = 16'h0010, acc = 16'h0100;
    wire  [31:0] flash;
    wire  [11:0] tq [3];
    wire  [15:0] speed, rate, elapsed;
    wire  [1:0]  stage;
    wire         alarm, dact, rated;
    int          err_total = 0, n_checks = 0, exp_tq [3];
    // 100 MHz system clock
    always #5 clk = ~clk;
    ssbp_top u_dut (
        .sys_clk_i(clk), .rstn_i(rstn), .torque_limit_two_cmd_i(cmd[0]),
        .torque_limit_three_four_cmd_i(cmd[1]), .torque_sel_four_i(sel4),
        .torque_limit_val_i(tval), .stall_protect_cmd_i(cmd[2]),
        .disable_stop_action_cmd_i(cmd[3]), .error_stop_action_cmd_i(cmd[4]),
        .disable_brake_max_time_cmd_i(cmd[5]), .error_brake_max_time_cmd_i(cmd[6]),
        .time_val_i(time_v), .action_val_i(act), .warning_display_mask_i(mask),
        .warning_active_i(wact), .servo_on_i(son), .error_i(err), .pos_mode_i(pos),
        .at_rated_current_i(rated), .motor_speed_i(speed),
        .zero_speed_threshold_i(thr), .max_accel_decel_i(acc),
        .warning_flash_o(flash), .torque_limit_two_o(tq[0]), .torque_limit_three_o(tq[1]),
        .torque_limit_four_o(tq[2]), .stall_alarm_o(alarm), .stage_mode_o(stage),
        .decel_rate_o(rate), .decel_active_o(dact), .brake_elapsed_ms_o(elapsed));
    ssbp_motor_model u_motor (
        .sys_clk_i(clk), .rstn_i(rstn), .load_i(load), .stall_i(stall),
        .stage_mode_i(stage), .decel_rate_i(rate), .start_speed_i(16'h0800),
        .motor_speed_o(speed), .at_rated_current_o(rated));
    // Stall timer at ten cycles per ms, so a stall alarm fits in a short run
    defparam u_dut.u_stall_timer.CYC_PER_MS = 10;
    // ********
    // Helpers
    // ********
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        n_checks++;
        if (seen !== expv) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, expv, seen);
        end
    endtask
    // One command strobe, held across one rising edge
    task automatic strobe(input int k);
        @(negedge clk) cmd[k] = 1'b1;
        @(negedge clk) cmd = 7'h0;
    endtask
    task automatic wait_dact(input logic lvl, input int lim);
        for (int i = 0; i < lim && dact !== lvl; i++) @(negedge clk);
        chk("decel flag", dact, lvl);
    endtask
    task automatic start_run;
        load = 1'b1;
        son = 1'b1;
        @(negedge clk) load = 1'b0;
        repeat (3) @(negedge clk);
        chk("stage run", stage, 2'h0);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Cut a hang short well past the expected few thousand cycles
    initial begin
        #200000;
        err_total++;
        complete_run();
    end
    initial begin
        exp_tq = '{3000, 3000, 3000};
        repeat (20) @(negedge clk);
        // Looked at while reset still holds: with servo off a stop begins once released
        for (int k = 0; k < 3; k++) chk("torque reset", tq[k], exp_tq[k]);
        chk("alarm decel stage", {alarm, dact, stage}, 4'h0);
        rstn = 1'b1;
        @(negedge clk);
        // Each limit loads a random legal value, then refuses one past the top
        for (int k = 0; k < 3; k++) begin
            seed = xs(seed);
            tval = 12'(seed % 32'hbb9);
            sel4 = (k == 2);
            strobe(k > 0);
            exp_tq[k] = tval;
            tval = 12'hbb9;
            strobe(k > 0);
            chk("torque", tq[k], exp_tq[k]);
        end
        repeat (4) begin
            seed = xs(seed);
            wact = seed;
            mask = xs(seed);
            repeat (2) @(negedge clk);
            chk("flash", flash, wact & ~mask);
        end
        $display("settings tests done");
        // All six disable codes, each followed by a refused code
        for (int c = 0; c < 6; c++) begin
            act = c[2:0];
            strobe(3);
            act = 3'h6;
            strobe(3);
            // Odd runs judge the stop against a negative threshold of the same size
            thr = c[0] ? 16'hfff0 : 16'h0010;
            seed = xs(seed);
            acc = {8'h01, seed[7:0]};
            start_run();
            son = 1'b0;
            wait_dact(1'b1, 4);
            chk("stage decel", stage, c / 2 + 1);
            chk("rate", rate, acc);
            wait_dact(1'b0, 3000);
            chk("stage stop", stage, 2 + c % 2);
            chk("speed low", speed <= 16'h0010 && elapsed === 16'h0, 1);
        end
        $display("disable tests done");
        // Error time stays 0, so every error stop ends at once with the shaft still turning
        time_v = 16'h7531;
        strobe(6);
        for (int c = 0; c < 4; c++) begin
            act = c[2:0];
            strobe(4);
            act = 3'h4;
            strobe(4);
            start_run();
            err = 1'b1;
            @(negedge clk);
            chk("error decel", stage, 2 + c / 2);
            repeat (3) @(negedge clk);
            chk("error stage", stage, 2'h2);
            chk("error early end", speed > 16'h0010 && dact === 1'b0, 1);
            err = 1'b0;
            son = 1'b0;
            @(negedge clk);
        end
        $display("error tests done");
        // Zero disable time cuts the stop; the brake lets go although the shaft turns
        time_v = 16'h0;
        strobe(5);
        act = 3'h5;
        strobe(3);
        start_run();
        son = 1'b0;
        repeat (4) @(negedge clk);
        chk("brake cut", {stage, dact, speed > 16'h0010}, 4'h9);
        // Short random stall time: alarm one edge after the count passes it
        seed = xs(seed);
        time_v = 16'(seed % 32'h4);
        strobe(2);
        start_run();
        pos = 1'b1;
        stall = 1'b1;
        repeat (11 + 10 * time_v) @(negedge clk);
        chk("alarm early", alarm, 1'b0);
        @(negedge clk);
        chk("alarm", alarm, 1'b1);
        repeat (4) @(negedge clk);
        chk("alarm stop", {stage, dact}, 3'h4);
        stall = 1'b0;
        pos = 1'b0;
        son = 1'b0;
        repeat (2) @(negedge clk);
        chk("alarm clear", alarm, 1'b0);
        $display("stall and cut tests done");
        complete_run();
    end
endmodule  // servo_stop_brake_protection_bench
`default_nettype wire

// ===== tb/ssbp_checker_asserts.sv
// Assertion checker for the stop, brake and stall block
`default_nettype none
module ssbp_checker #(parameter int SPW = 16) (
    input wire logic           sys_clk_i,
    input wire logic           rstn_i,
    input wire logic           torque_limit_two_cmd_i,
    input wire logic [11:0]    torque_limit_val_i,
    input wire logic [11:0]    torque_limit_two_o,
    input wire logic [31:0]    warning_display_mask_i,
    input wire logic [31:0]    warning_active_i,
    input wire logic [31:0]    warning_flash_o,
    input wire logic           servo_on_i,
    input wire logic [1:0]     stage_mode_o,
    input wire logic           decel_active_o,
    input wire logic [15:0]    brake_elapsed_ms_o,
    input wire logic [SPW-1:0] motor_speed_i,
    input wire logic [SPW-1:0] zero_speed_threshold_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SPW-1:0] spd_mag;
    logic [SPW-1:0] thr_mag;
    // Both are signed; a stop is judged on size, not direction
    assign spd_mag = motor_speed_i[SPW-1] ? -motor_speed_i : motor_speed_i;
    assign thr_mag = zero_speed_threshold_i[SPW-1] ?
        -zero_speed_threshold_i : zero_speed_threshold_i;
    // ********
    // Checks
    // ********
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_flash_masked: assert property ($past(rstn_i) |->
        warning_flash_o == $past(warning_active_i & ~warning_display_mask_i)) else $error("flash");
    a_limit_load: assert property (torque_limit_two_cmd_i && torque_limit_val_i <= 12'hbb8 |=>
        torque_limit_two_o == $past(torque_limit_val_i)) else $error("limit not loaded");
    a_limit_hold: assert property (!torque_limit_two_cmd_i |=> $stable(torque_limit_two_o))
        else $error("limit moved");
    a_limit_range: assert property (torque_limit_two_o <= 12'hbb8)
        else $error("limit out of range");
    a_stop_start: assert property ($fell(servo_on_i) && stage_mode_o == 2'h0 |->
        ##[1:2] stage_mode_o != 2'h0) else $error("no stop");
    // Elapsed time lags the stop flag by two registers, so idle means three quiet cycles
    a_elapsed_idle: assert property (!decel_active_o && !$past(decel_active_o) &&
        !$past(decel_active_o, 2) |-> brake_elapsed_ms_o == 16'h0) else $error("timer runs idle");
    a_zero_end: assert property (decel_active_o && spd_mag <= thr_mag |->
        ##[1:2] !decel_active_o) else $error("stop not ended");
    a_done_stage: assert property ($fell(decel_active_o) && !servo_on_i |->
        stage_mode_o[1]) else $error("bad after-stop stage");
    c_ramp: cover property (decel_active_o && stage_mode_o == 2'h1);
    c_hold: cover property ($fell(decel_active_o) && stage_mode_o == 2'h3);
    c_refused: cover property (torque_limit_two_cmd_i && torque_limit_val_i > 12'hbb8);
endmodule  // ssbp_checker
bind ssbp_top ssbp_checker #(.SPW(SPW)) u_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .torque_limit_two_cmd_i(torque_limit_two_cmd_i),
    .torque_limit_val_i(torque_limit_val_i), .torque_limit_two_o(torque_limit_two_o),
    .warning_display_mask_i(warning_display_mask_i), .warning_active_i(warning_active_i),
    .warning_flash_o(warning_flash_o), .servo_on_i(servo_on_i), .stage_mode_o(stage_mode_o),
    .decel_active_o(decel_active_o), .brake_elapsed_ms_o(brake_elapsed_ms_o),
    .motor_speed_i(motor_speed_i), .zero_speed_threshold_i(zero_speed_threshold_i));
`default_nettype wire

// ===== tb/ssbp_motor_model.sv
// Motor and brake power stage model facing the stop block
`default_nettype none
module ssbp_motor_model (
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic        load_i,
    input wire logic        stall_i,
    input wire logic [1:0]  stage_mode_i,
    input wire logic [15:0] decel_rate_i,
    input wire logic [15:0] start_speed_i,
    output logic     [15:0] motor_speed_o,
    output logic            at_rated_current_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] step;
    logic [15:0] speed_q;
    // Ramp follows the rate, the brake bites hard, coasting drifts slowly
    assign step = stage_mode_i == 2'h1 ? decel_rate_i :
        stage_mode_i == 2'h3 ? 16'h0040 : {15'h0, stage_mode_i[1]};
    // Speed never wraps below zero
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            speed_q <= 16'h0;
        end else if (load_i) begin
            speed_q <= start_speed_i;
        end else begin
            speed_q <= (speed_q > step) ? speed_q - step : 16'h0;
        end
    end
    // Full current only while driven against a blocked shaft
    assign motor_speed_o = speed_q;
    assign at_rated_current_o = stall_i && (stage_mode_i == 2'h0);
endmodule  // ssbp_motor_model
`default_nettype wire
